/* laser_drive_setting_regs.sv */
// module: laser drive setting register bank
`timescale 1ns/1ps
module laser_drive_setting_regs (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register access from the serial interface engine
	input wire logic [7:0] cmdCode,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [15:0] wrData,
	output logic [15:0] rdData,
	output logic rdValid,
	output logic cmdHit,
	// mode selection from the control register
	input wire logic apcEnable,
	// analog settings
	output logic [4:0] peakLevel,
	output logic [1:0] srcCurrentRange,
	output logic [7:0] fullScaleMa,
	output logic [9:0] biasCurrentSetting,
	output logic [9:0] monitorCurrentSetting,
	output logic [6:0] factoryTest
);
	ldsr_pkg::ldsr_sel_t sel;
	ldsr_pkg::ldsr_setting_t setting;
	logic [15:0] next_rdData;

	ldsr_decode uDecode (
		.cmdCode(cmdCode),
		.sel(sel)
	);

	// peaking register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			setting.peakLevel <= ldsr_pkg::PEAK_RESET;
		end else if (wrStrobe && sel == ldsr_pkg::SEL_PEAK) begin
			setting.peakLevel <= wrData[ldsr_pkg::PEAK_W-1:0];
		end
	end

	// peaking storage checks
	a_peak_write: assert property (@(posedge clk_sys) disable iff (rst)
		wrStrobe && sel == ldsr_pkg::SEL_PEAK |=> setting.peakLevel == $past(wrData[4:0]))
		else $error("peaking level not stored");
	a_peak_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!(wrStrobe && sel == ldsr_pkg::SEL_PEAK) |=> $stable(setting.peakLevel))
		else $error("peaking level changed without write");

	// bias and monitor current register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			setting.srcCurrentRange <= ldsr_pkg::RNG_RESET;
			setting.nominalBiasSetting <= ldsr_pkg::NOM_RESET;
		end else if (wrStrobe && sel == ldsr_pkg::SEL_BIAS) begin
			setting.srcCurrentRange <= wrData[ldsr_pkg::RNG_LSB +: ldsr_pkg::RNG_W];
			setting.nominalBiasSetting <= wrData[ldsr_pkg::NOM_W-1:0];
		end
	end

	// bias register storage checks
	a_range_write: assert property (@(posedge clk_sys) disable iff (rst)
		wrStrobe && sel == ldsr_pkg::SEL_BIAS |=> setting.srcCurrentRange == $past(wrData[11:10]))
		else $error("range field not stored");
	a_nominal_write: assert property (@(posedge clk_sys) disable iff (rst)
		wrStrobe && sel == ldsr_pkg::SEL_BIAS |=> setting.nominalBiasSetting == $past(wrData[9:0]))
		else $error("nominal setting not stored");
	a_range_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!(wrStrobe && sel == ldsr_pkg::SEL_BIAS) |=> $stable(setting.srcCurrentRange))
		else $error("range field changed without write");
	a_nominal_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!(wrStrobe && sel == ldsr_pkg::SEL_BIAS) |=> $stable(setting.nominalBiasSetting))
		else $error("nominal setting changed without write");

	// test register, still writable so the host duty is not assumed
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			factoryTest <= ldsr_pkg::TEST_RESET;
		end else if (wrStrobe && sel == ldsr_pkg::SEL_TEST) begin
			factoryTest <= wrData[ldsr_pkg::TEST_W-1:0];
		end
	end

	// test register and unmapped write checks
	a_test_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!(wrStrobe && sel == ldsr_pkg::SEL_TEST) |=> $stable(factoryTest))
		else $error("test register changed without write");
	a_unmapped_write: assert property (@(posedge clk_sys) disable iff (rst)
		wrStrobe && sel == ldsr_pkg::SEL_NONE |=> $stable(setting) && $stable(factoryTest))
		else $error("unmapped write changed a register");

	// read mux
	always_comb begin
		next_rdData = '0;
		case (sel)
			ldsr_pkg::SEL_PEAK: next_rdData[ldsr_pkg::PEAK_W-1:0] = setting.peakLevel;
			ldsr_pkg::SEL_BIAS: begin
				next_rdData[ldsr_pkg::RNG_LSB +: ldsr_pkg::RNG_W] = setting.srcCurrentRange;
				next_rdData[ldsr_pkg::NOM_W-1:0] = setting.nominalBiasSetting;
			end
			ldsr_pkg::SEL_TEST: next_rdData[ldsr_pkg::TEST_W-1:0] = factoryTest;
			default: next_rdData = '0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdData <= '0;
			rdValid <= 1'b0;
			cmdHit <= 1'b0;
		end else begin
			rdValid <= rdStrobe;
			cmdHit <= (rdStrobe || wrStrobe) && sel != ldsr_pkg::SEL_NONE;
			if (rdStrobe) begin
				rdData <= next_rdData;
			end
		end
	end

	// read port checks
	a_read_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		rdValid == $past(rdStrobe))
		else $error("read valid not one cycle after strobe");
	a_write_no_valid: assert property (@(posedge clk_sys) disable iff (rst)
		wrStrobe && !rdStrobe |=> !rdValid)
		else $error("write produced read valid");
	a_unmapped_rd_valid: assert property (@(posedge clk_sys) disable iff (rst)
		rdStrobe && sel == ldsr_pkg::SEL_NONE |=> rdValid)
		else $error("unmapped read not answered");
	a_hit_mapped: assert property (@(posedge clk_sys) disable iff (rst)
		(rdStrobe || wrStrobe) && sel != ldsr_pkg::SEL_NONE |=> cmdHit)
		else $error("mapped access not flagged");
	a_hit_unmapped: assert property (@(posedge clk_sys) disable iff (rst)
		sel == ldsr_pkg::SEL_NONE |=> !cmdHit)
		else $error("unmapped code flagged");
	a_read_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!rdStrobe |=> $stable(rdData))
		else $error("read data changed without strobe");
	a_peak_readback: assert property (@(posedge clk_sys) disable iff (rst)
		rdStrobe && sel == ldsr_pkg::SEL_PEAK |=> rdData[4:0] == $past(setting.peakLevel))
		else $error("peaking readback wrong");
	a_test_readback: assert property (@(posedge clk_sys) disable iff (rst)
		rdStrobe && sel == ldsr_pkg::SEL_TEST |=> rdData[6:0] == $past(factoryTest))
		else $error("test register readback wrong");
	a_range_readback: assert property (@(posedge clk_sys) disable iff (rst)
		rdStrobe && sel == ldsr_pkg::SEL_BIAS |=> rdData[11:10] == $past(setting.srcCurrentRange))
		else $error("range readback wrong");
	a_nominal_top: assert property (@(posedge clk_sys) disable iff (rst)
		rdStrobe && sel == ldsr_pkg::SEL_BIAS |=> rdData[9] == $past(setting.nominalBiasSetting[9]))
		else $error("nominal top bit readback wrong");

	// analog outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			peakLevel <= ldsr_pkg::PEAK_RESET;
			srcCurrentRange <= ldsr_pkg::RNG_RESET;
			fullScaleMa <= ldsr_pkg::FS_MA_STEP;
			biasCurrentSetting <= ldsr_pkg::NOM_RESET;
			monitorCurrentSetting <= ldsr_pkg::NOM_RESET;
		end else begin
			peakLevel <= setting.peakLevel;
			srcCurrentRange <= setting.srcCurrentRange;
			fullScaleMa <= 8'((setting.srcCurrentRange + 3'h1) * ldsr_pkg::FS_MA_STEP);
			biasCurrentSetting <= apcEnable ? ldsr_pkg::NOM_RESET
				: setting.nominalBiasSetting;
			monitorCurrentSetting <= apcEnable ? setting.nominalBiasSetting
				: ldsr_pkg::NOM_RESET;
		end
	end

	// analog output checks
	a_peak_copy: assert property (@(posedge clk_sys) disable iff (rst)
		peakLevel == $past(setting.peakLevel))
		else $error("peaking output not following register");
	a_range_copy: assert property (@(posedge clk_sys) disable iff (rst)
		srcCurrentRange == $past(setting.srcCurrentRange))
		else $error("range output not following register");
	a_scale_follow: assert property (@(posedge clk_sys) disable iff (rst)
		fullScaleMa == 8'(({6'h00, $past(setting.srcCurrentRange)} + 8'h01) * ldsr_pkg::FS_MA_STEP))
		else $error("full scale not following range");
	a_bias_value: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(apcEnable) |-> biasCurrentSetting == $past(setting.nominalBiasSetting))
		else $error("bias setting wrong in constant current mode");
	a_monitor_value: assert property (@(posedge clk_sys) disable iff (rst)
		$past(apcEnable) |-> monitorCurrentSetting == $past(setting.nominalBiasSetting))
		else $error("monitor setting wrong in power control mode");
	a_monitor_split: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(apcEnable) |-> monitorCurrentSetting == 10'h000)
		else $error("monitor setting active in constant current mode");

	a_peak_follows: assert property (@(posedge clk_sys) disable iff (rst)
		wrStrobe && sel == ldsr_pkg::SEL_PEAK |=> ##1 peakLevel == $past(wrData[4:0], 2))
		else $error("peaking level not applied");
	a_peak_reserved: assert property (@(posedge clk_sys) disable iff (rst)
		rdValid && $past(sel) == ldsr_pkg::SEL_PEAK |-> rdData[15:5] == 11'h000)
		else $error("peaking reserved bits nonzero");
	a_bias_reserved: assert property (@(posedge clk_sys) disable iff (rst)
		rdValid && $past(sel) == ldsr_pkg::SEL_BIAS |-> rdData[15:12] == 4'h0)
		else $error("bias reserved bits nonzero");
	a_test_reserved: assert property (@(posedge clk_sys) disable iff (rst)
		rdValid && $past(sel) == ldsr_pkg::SEL_TEST |-> rdData[15:7] == 9'h000)
		else $error("test reserved bits nonzero");
	a_range_scale: assert property (@(posedge clk_sys) disable iff (rst)
		fullScaleMa == 8'((srcCurrentRange + 3'h1) * 8'h09) || $changed(srcCurrentRange))
		else $error("full scale mismatch");
	a_mode_split: assert property (@(posedge clk_sys) disable iff (rst)
		$past(apcEnable) |-> biasCurrentSetting == 10'h000)
		else $error("bias setting active in power control mode");
	a_bias_read: assert property (@(posedge clk_sys) disable iff (rst)
		rdStrobe && sel == ldsr_pkg::SEL_BIAS && !wrStrobe
		|=> rdData[9:0] == $past(setting.nominalBiasSetting))
		else $error("nominal setting readback wrong");
	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
		rdStrobe && sel == ldsr_pkg::SEL_NONE |=> rdData == 16'h0000 && !cmdHit)
		else $error("unmapped command answered");
endmodule

/* ldsr_decode.sv */
// module: command code decode for the setting bank
`timescale 1ns/1ps
module ldsr_decode (
	// command
	input wire logic [7:0] cmdCode,
	// selection
	output ldsr_pkg::ldsr_sel_t sel
);
	always_comb begin
		case (cmdCode)
			ldsr_pkg::CMD_PEAKING: sel = ldsr_pkg::SEL_PEAK;
			ldsr_pkg::CMD_BIAS: sel = ldsr_pkg::SEL_BIAS;
			ldsr_pkg::CMD_TEST: sel = ldsr_pkg::SEL_TEST;
			default: sel = ldsr_pkg::SEL_NONE;
		endcase
	end
endmodule

/* ldsr_host.sv */
// host model driving the setting bank register port
`timescale 1ns/1ps
module ldsr_host (
	// clock
	input wire logic clk_sys,
	// register access
	output logic [7:0] cmdCode,
	output logic wrStrobe,
	output logic rdStrobe,
	output logic [15:0] wrData,
	input wire logic [15:0] rdData
);
	initial begin
		{cmdCode, wrStrobe, rdStrobe, wrData} = '0;
	end
	task automatic acc(input logic wr, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clk_sys) #1;
		cmdCode = c;
		wrData = d;
		wrStrobe = wr && (c !== ldsr_pkg::CMD_TEST);
		rdStrobe = !wr;
		@(posedge clk_sys) #1;
		{wrStrobe, rdStrobe} = 2'h0;
		wrData = ~d;
		q = rdData;
	endtask
endmodule

/* ldsr_pkg.sv */
// package: register map, field layout and reset values for the laser drive setting bank
package ldsr_pkg;
	localparam int DATA_W = 16;
	localparam int CMD_W = 8;
	localparam logic [7:0] CMD_PEAKING = 8'h1f;
	localparam logic [7:0] CMD_BIAS = 8'h15;
	localparam logic [7:0] CMD_TEST = 8'h08;
	localparam int PEAK_W = 5;
	localparam logic [4:0] PEAK_RESET = 5'h10;
	localparam int TEST_W = 7;
	localparam logic [6:0] TEST_RESET = 7'h44;
	localparam int RNG_W = 2;
	localparam int RNG_LSB = 10;
	localparam logic [1:0] RNG_RESET = 2'h0;
	localparam int NOM_W = 10;
	localparam logic [9:0] NOM_RESET = 10'h000;
	localparam logic [7:0] FS_MA_STEP = 8'h09;
	typedef struct packed {
		logic [4:0] peakLevel;
		logic [1:0] srcCurrentRange;
		logic [9:0] nominalBiasSetting;
	} ldsr_setting_t;
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_PEAK = 2'b01,
		SEL_BIAS = 2'b11,
		SEL_TEST = 2'b10
	} ldsr_sel_t;
endpackage

/* testbench.sv */
// self-checking bench for the laser drive setting bank
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic apcEnable = 1'b0;
	logic wrStrobe, rdStrobe, rdValid, cmdHit;
	logic [7:0] cmdCode, fullScaleMa;
	logic [15:0] wrData, rdData, q;
	logic [15:0] expBias = 16'h0000;
	logic [4:0] peakLevel;
	logic [1:0] srcCurrentRange;
	logic [9:0] biasCurrentSetting, monitorCurrentSetting;
	logic [6:0] factoryTest;
	logic [39:0] rows [6] = '{{8'h1f, 16'hffff, 16'h001f}, {8'h15, 16'hffff, 16'h0fff},
		{8'h40, 16'h1234, 16'h0000}, {8'h15, 16'h0a5a, 16'h0a5a},
		{8'h1f, 16'h0003, 16'h0003}, {8'h15, 16'h0600, 16'h0600}};
	int err_total = 0;
	int checks = 0;
	always #12.5 clk_sys = ~clk_sys;
	laser_drive_setting_regs u_dut (.clk_sys(clk_sys), .rst(rst), .cmdCode(cmdCode),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData),
		.rdValid(rdValid), .cmdHit(cmdHit), .apcEnable(apcEnable), .peakLevel(peakLevel),
		.srcCurrentRange(srcCurrentRange), .fullScaleMa(fullScaleMa),
		.biasCurrentSetting(biasCurrentSetting), .monitorCurrentSetting(monitorCurrentSetting),
		.factoryTest(factoryTest));
	ldsr_host u_host (.clk_sys(clk_sys), .cmdCode(cmdCode), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#10000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk(16'(peakLevel), 16'h0010);
		chk(16'(fullScaleMa), 16'h0009);
		u_host.acc(1'b0, 8'h08, 16'h0, q);
		chk(q, 16'h0044);
		chk(16'({rdValid, cmdHit}), 16'h0003);
		u_host.acc(1'b0, 8'h15, 16'h0, q);
		chk(q, 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			u_host.acc(1'b1, rows[i][39:32], rows[i][31:16], q);
			u_host.acc(1'b0, rows[i][39:32], 16'h0, q);
			chk(q, rows[i][15:0]);
			chk(16'(cmdHit), 16'(rows[i][39:32] != 8'h40));
			if (rows[i][39:32] == 8'h15) expBias = rows[i][15:0];
			if (rows[i][39:32] == 8'h1f) chk(16'(peakLevel), 16'(rows[i][4:0]));
			else chk(16'(fullScaleMa), 16'((expBias[11:10] + 8'h1) * 8'h9));
			chk(16'(srcCurrentRange), 16'(expBias[11:10]));
			$display("row %0d done", i);
		end
		u_host.acc(1'b1, 8'h08, 16'h007f, q);
		u_host.acc(1'b0, 8'h08, 16'h0, q);
		chk(16'({factoryTest, q[6:0]}), 16'h2244);
		chk(16'(biasCurrentSetting), 16'h0200);
		chk(16'(monitorCurrentSetting), 16'h0000);
		apcEnable = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk(16'(monitorCurrentSetting), 16'h0200);
		chk(16'(biasCurrentSetting), 16'h0000);
		$display("mode test done");
		rst = 1'b1;
		#1 chk(16'(peakLevel), 16'h0010);
		chk(16'(srcCurrentRange), 16'h0000);
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk(16'(monitorCurrentSetting), 16'h0000);
		chk(16'(factoryTest), 16'h0044);
		u_host.acc(1'b0, 8'h1f, 16'h0, q);
		chk(q, 16'h0010);
		u_host.acc(1'b0, 8'h15, 16'h0, q);
		chk(q, 16'h0000);
		$display("mid-run reset test done");
		print_verdict();
	end
endmodule
